// ==== dv/rps_button_host.sv ====
// Purpose: far side of the reset pin, pushbutton plus host reset input
// Assumes: pin is open drain with a pullup, button shorts it to ground
// Notes: wire-AND of pullup, button and device drive
`timescale 1ns/100ps
module rps_button_host (
   input wire logic btn_press,
   input wire logic pin_o,
   input wire logic pin_oe_n,
   output logic pin_level,
   output logic host_rst_n
);
   // Pullup wins only when nobody pulls; never left floating
   assign pin_level = ~btn_press & (pin_oe_n | pin_o);
   // Host simply follows the pin level
   assign host_rst_n = pin_level;
endmodule // rps_button_host

// ==== dv/tb_reset_pin_supervisor.sv ====
// Purpose: self-checking bench for the reset pin supervisor
// Assumes: short intervals, oscillator tick every 6 system cycles
// Notes: bounds allow one tick of jitter plus synchroniser delay
`timescale 1ns/100ps
module tb_reset_pin_supervisor;
   localparam int DB_T = 3;
   localparam int RC_T = 4;
   localparam int AC_T = 5;
   localparam int TK = 6;
   typedef struct {logic run; logic dis; logic slow;} rps_row_t;
   rps_row_t rows [4] = '{'{1'h1, 1'h0, 1'h1}, '{1'h0, 1'h0, 1'h0}, '{1'h1, 1'h1, 1'h0}, '{1'h0, 1'h1, 1'h0}};
   logic clk_sys = 1'h0, rst_n = 1'h0, ce = 1'h1, osc_32k = 1'h0, osc_running = 1'h1;
   logic osc_disable_bit = 1'h0, pwr_fail = 1'h0, btn = 1'h0;
   logic pin, pin_o, pin_oe_n, reset_cycle, host_rst_n;
   int bad_count = 0, comparisons = 0, n;
   // System clock
   initial forever #5 clk_sys = ~clk_sys;
   // Oscillator period of TK cycles, changed just after the rising edge like every input
   initial begin
      forever begin
         repeat (TK / 2) @(posedge clk_sys);
         #1;
         osc_32k = ~osc_32k;
      end
   end
   rps_supervisor #(.DEBOUNCE_T(DB_T), .RECOVERY_T(RC_T), .ACTIVE_T(AC_T)) i_dut (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .CE(ce), .OSC_32K(osc_32k), .OSC_RUNNING(osc_running), .OSC_DISABLE_BIT(osc_disable_bit),
      .PWR_FAIL(pwr_fail), .RST_PIN_I(pin), .RST_PIN_O(pin_o), .RST_PIN_OE_N(pin_oe_n), .RESET_CYCLE(reset_cycle));
   rps_button_host i_far (.btn_press(btn), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .pin_level(pin),
      .host_rst_n(host_rst_n));
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'h1) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask
   // Inputs always change 1 ns after the rising edge
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask
   // Cycles until the device lets go of the pin, bounded
   task automatic low_len(output int len);
      len = 0;
      while (pin_oe_n !== 1'h1 && len < 300) begin
         cyc(1);
         len++;
      end
   endtask
   function automatic logic in_rng(input int v, input int t);
      return v >= (t - 1) * TK && v <= (t + 2) * TK;
   endfunction
   task automatic end_of_test;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Hang guard, far beyond the expected few hundred cycles
   initial begin
      #200000;
      bad_count++;
      end_of_test();
   end
   initial begin
      cyc(10);
      chk(pin_oe_n === 1'h0 && reset_cycle === 1'h1, "pin not held in reset");
      chk(pin_o === 1'h0, "pin drive level not low");
      rst_n = 1'h1;
      low_len(n);
      chk(in_rng(n, RC_T), "power-up recovery length");
      // Power fail with each oscillator condition
      foreach (rows[i]) begin
         osc_running = rows[i].run;
         osc_disable_bit = rows[i].dis;
         pwr_fail = 1'h1;
         cyc(3);
         chk(pin_oe_n === 1'h0, "no pull on power fail");
         cyc(20);
         pwr_fail = 1'h0;
         low_len(n);
         chk(rows[i].slow ? in_rng(n, RC_T) : n == 3, "release timing");
         cyc(5);
      end
      // Pushbutton held past the debounce, then released
      osc_running = 1'h1;
      osc_disable_bit = 1'h0;
      btn = 1'h1;
      cyc(2);
      chk(pin_oe_n === 1'h0 && reset_cycle === 1'h1, "no debounce pull");
      low_len(n);
      chk(in_rng(n + 2, DB_T), "debounce length");
      cyc(10);
      chk(pin_oe_n === 1'h1 && reset_cycle === 1'h1, "pulse before release");
      btn = 1'h0;
      cyc(3);
      chk(pin_oe_n === 1'h0, "no reset pulse");
      low_len(n);
      chk(in_rng(n + 2, AC_T), "pulse length");
      cyc(2);
      chk(reset_cycle === 1'h0 && host_rst_n === 1'h1, "cycle not ended");
      // Button let go during the debounce; the pulse still follows
      btn = 1'h1;
      cyc(2);
      btn = 1'h0;
      low_len(n);
      chk(in_rng(n + 2, DB_T), "short press debounce length");
      cyc(1);
      chk(pin_oe_n === 1'h0 && reset_cycle === 1'h1, "no pulse after short press");
      low_len(n);
      chk(in_rng(n, AC_T), "short press pulse length");
      // Frozen clock enable stalls a recovery count already under way
      pwr_fail = 1'h1;
      cyc(5);
      pwr_fail = 1'h0;
      cyc(4);
      ce = 1'h0;
      cyc(60);
      chk(pin_oe_n === 1'h0, "recovery ran while frozen");
      ce = 1'h1;
      low_len(n);
      chk(n >= (RC_T - 3) * TK && n <= (RC_T + 2) * TK, "recovery after unfreeze");
      // Second reset in mid-run
      rst_n = 1'h0;
      cyc(2);
      chk(pin_oe_n === 1'h0 && reset_cycle === 1'h1, "mid-run reset");
      rst_n = 1'h1;
      low_len(n);
      chk(in_rng(n, RC_T), "recovery after reset");
      end_of_test();
   end
endmodule // tb_reset_pin_supervisor

// ==== rtl/rps_pkg.sv ====
// Purpose: constants for the reset pin supervisor
// Assumes: 100 MHz system clock, 32 kHz oscillator tick arrives as a level input
// Notes: all intervals are counted in oscillator ticks
package rps_pkg;
   // Oscillator tick rate and the three intervals, in ms
   localparam int OSC_HZ = 32768;
   localparam int DEBOUNCE_MS = 250;
   localparam int RECOVERY_MS = 250;
   localparam int RST_ACTIVE_MS = 250;
   // Intervals in oscillator ticks, rounded down
   localparam int DEBOUNCE_TICKS = (OSC_HZ * DEBOUNCE_MS) / 1000;
   localparam int RECOVERY_TICKS = (OSC_HZ * RECOVERY_MS) / 1000;
   localparam int RST_ACTIVE_TICKS = (OSC_HZ * RST_ACTIVE_MS) / 1000;
   localparam int TICK_W = 16;
   // Reset values
   localparam logic [1:0] SYNC_RST = 2'h3;
   // Supervisor states, Gray along the usual path
   typedef enum logic [2:0] {
      RPS_IDLE     = 3'h0,
      RPS_DEBOUNCE = 3'h1,
      RPS_WAIT_REL = 3'h3,
      RPS_PULSE    = 3'h2,
      RPS_PWRFAIL  = 3'h6,
      RPS_RECOVER  = 3'h4
   } rps_state_t;
endpackage

// ==== rtl/rps_supervisor.sv ====
// Purpose: drives and watches the active-low open-drain reset pin
// Assumes: RST_N is the power-on reset; inputs other than PWR_FAIL and OSC_32K synchronous to CLK_SYS
// Notes: pin output is always low when enabled; OE low means driving
//
// Overview of operation
// - Pull the reset pin low while supply is below power-fail threshold.
// - Release pin after supply stays good for the recovery delay.
// - Recovery delay applies only with oscillator running; disable bit skips it.
// - Pin level never affects serial, counters or compensated oscillator.
// - External low on pin is a reset request, debounced before pulsing.
// - Hold pin low about 250 ms after supply recovers, oscillator running.
// - Outside a reset cycle, falling edge drives low for debounce, then resample.
// - On button release drive pin low for the reset active time.
`timescale 1ns/100ps
module rps_supervisor #(
   parameter int DEBOUNCE_T = rps_pkg::DEBOUNCE_TICKS,
   parameter int RECOVERY_T = rps_pkg::RECOVERY_TICKS,
   parameter int ACTIVE_T = rps_pkg::RST_ACTIVE_TICKS
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic OSC_32K,
   input wire logic OSC_RUNNING,
   input wire logic OSC_DISABLE_BIT,
   input wire logic PWR_FAIL,
   input wire logic RST_PIN_I,
   output logic RST_PIN_O,
   output logic RST_PIN_OE_N,
   output logic RESET_CYCLE
);
   localparam int W = rps_pkg::TICK_W;
   rps_pkg::rps_state_t state_r, state_nxt;
   logic [1:0] pf_sync_r;
   logic [1:0] osc_sync_r;
   logic osc_prev_r;
   logic pin_prev_r;
   logic drive_r;
   logic tick, pf, fall_edge, rise_edge, load, tmr_done, drive_nxt, recover_ok;
   logic [W-1:0] load_val;

   // Comparator and oscillator are asynchronous; two stages each
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pf_sync_r <= rps_pkg::SYNC_RST;
         osc_sync_r <= 2'h0;
         osc_prev_r <= 1'b0;
         pin_prev_r <= 1'b1;
      end else if (CE) begin
         pf_sync_r <= {pf_sync_r[0], PWR_FAIL};
         osc_sync_r <= {osc_sync_r[0], OSC_32K};
         osc_prev_r <= osc_sync_r[1];
         pin_prev_r <= RST_PIN_I;
      end
   end

   // Tick and pin edge decoding
   assign pf = pf_sync_r[1];
   assign tick = osc_sync_r[1] & ~osc_prev_r;
   assign fall_edge = pin_prev_r & ~RST_PIN_I;
   assign rise_edge = ~pin_prev_r & RST_PIN_I;
   assign recover_ok = OSC_RUNNING & ~OSC_DISABLE_BIT;

   // Next state; power fail beats any pushbutton activity
   always_comb begin
      state_nxt = state_r;
      load = 1'b0;
      load_val = '0;
      if (pf) begin
         state_nxt = rps_pkg::RPS_PWRFAIL;
      end else begin
         case (state_r)
            rps_pkg::RPS_IDLE: begin
               if (fall_edge) begin
                  state_nxt = rps_pkg::RPS_DEBOUNCE;
                  load = 1'b1;
                  load_val = W'(DEBOUNCE_T);
               end
            end
            rps_pkg::RPS_DEBOUNCE: begin
               if (tmr_done) begin
                  // Resample with our drive off; pullup decides if released
                  state_nxt = rps_pkg::RPS_WAIT_REL;
               end
            end
            rps_pkg::RPS_WAIT_REL: begin
               if (RST_PIN_I && !drive_r) begin
                  state_nxt = rps_pkg::RPS_PULSE;
                  load = 1'b1;
                  load_val = W'(ACTIVE_T);
               end
            end
            rps_pkg::RPS_PULSE: begin
               if (tmr_done) begin
                  state_nxt = rps_pkg::RPS_IDLE;
               end
            end
            rps_pkg::RPS_PWRFAIL: begin
               if (recover_ok) begin
                  state_nxt = rps_pkg::RPS_RECOVER;
                  load = 1'b1;
                  load_val = W'(RECOVERY_T);
               end else begin
                  state_nxt = rps_pkg::RPS_IDLE;
               end
            end
            rps_pkg::RPS_RECOVER: begin
               if (tmr_done) begin
                  state_nxt = rps_pkg::RPS_IDLE;
               end
            end
            default: state_nxt = rps_pkg::RPS_IDLE;
         endcase
      end
   end

   // Drive low in every reset phase except the release wait
   assign drive_nxt = (state_nxt == rps_pkg::RPS_DEBOUNCE) || (state_nxt == rps_pkg::RPS_PULSE)
      || (state_nxt == rps_pkg::RPS_PWRFAIL) || (state_nxt == rps_pkg::RPS_RECOVER);

   // State and pin drive register; power-on starts in power fail
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_r <= rps_pkg::RPS_PWRFAIL;
         drive_r <= 1'b1;
      end else if (CE) begin
         state_r <= state_nxt;
         drive_r <= drive_nxt;
      end
   end

   rps_tick_timer #(
      .W(W)
   ) u_timer (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .ce(CE),
      .load(load),
      .load_val(load_val),
      .tick(tick),
      .done(tmr_done)
   );

   // Open drain: output always low, enable low while pulling
   assign RST_PIN_O = 1'b0;
   assign RST_PIN_OE_N = ~drive_r;
   // Status only; nothing here feeds serial, counters or oscillator control
   assign RESET_CYCLE = (state_r != rps_pkg::RPS_IDLE);

   // Power fail must reach the pin within sync plus one register
   a_pf_drives_pin: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && pf |=> !RST_PIN_OE_N)
      else $error("pin not driven during power fail");

   // Supply returning: power fail seen, gone on the next edge
   sequence s_pf_end;
      pf ##1 !pf;
   endsequence
   a_recover_entry: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      s_pf_end ##0 (CE && recover_ok && state_r == rps_pkg::RPS_PWRFAIL) |=> (!RST_PIN_OE_N && !tmr_done))
      else $error("recovery hold not started");

   // Oscillator stopped or disabled: let go at once
   a_bypass_release: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && !recover_ok && state_r == rps_pkg::RPS_PWRFAIL && !pf) |=> RST_PIN_OE_N)
      else $error("recovery not bypassed");

   // Pin stays pulled for the whole recovery count
   a_recover_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (state_r == rps_pkg::RPS_RECOVER && !tmr_done) |-> !RST_PIN_OE_N)
      else $error("pin released during recovery");

   // Count expired: pullup takes the pin high
   a_release_done: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_RECOVER && tmr_done && !pf) |=> RST_PIN_OE_N)
      else $error("pin held after recovery");

   a_push_debounce: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_IDLE && fall_edge && !pf)
      |=> (!RST_PIN_OE_N && state_r == rps_pkg::RPS_DEBOUNCE))
      else $error("falling edge not debounced");

   a_wait_no_drive: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      state_r == rps_pkg::RPS_WAIT_REL |-> RST_PIN_OE_N)
      else $error("driving while waiting for release");

   a_release_pulse: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_WAIT_REL && RST_PIN_I && !pf) |=> (!RST_PIN_OE_N && !tmr_done))
      else $error("no reset pulse after release");

   // A tick may stand while frozen, so only enabled cycles count
   a_tick_single: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && tick |=> !tick)
      else $error("tick longer than one cycle");

   a_status_mirror: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !RST_PIN_OE_N |-> RESET_CYCLE)
      else $error("driving outside a reset cycle");

   // Power fail wins over any pushbutton phase
   a_pf_override: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      CE && pf |=> state_r == rps_pkg::RPS_PWRFAIL)
      else $error("power fail did not take over");

   // Debounce over: let go of the pin and look at it again
   a_debounce_end: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_DEBOUNCE && tmr_done && !pf)
      |=> (RST_PIN_OE_N && state_r == rps_pkg::RPS_WAIT_REL))
      else $error("debounce did not end");

   // Button still held: keep waiting, no pulse yet
   a_wait_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_WAIT_REL && !RST_PIN_I && !pf) |=> state_r == rps_pkg::RPS_WAIT_REL)
      else $error("left wait while button held");

   // Pulse over: pin released and back to idle
   a_pulse_end: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (CE && state_r == rps_pkg::RPS_PULSE && tmr_done && !pf) |=> (RST_PIN_OE_N && !RESET_CYCLE))
      else $error("pulse did not end");

   // Low enable freezes state and pin drive; counts must not creep
   a_ce_freeze: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !CE |=> ($stable(state_r) && $stable(drive_r)))
      else $error("state moved while frozen");
endmodule // rps_supervisor

// ==== rtl/rps_tick_timer.sv ====
// Purpose: interval counter advanced by oscillator ticks
// Assumes: tick is a one-cycle pulse, load has priority
// Notes: done is a level once the count reaches zero
`timescale 1ns/100ps
module rps_tick_timer #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic tick,
   output logic done
);
   logic [W-1:0] cnt_r;
   // Done while counter idles at zero
   assign done = (cnt_r == '0);
   // Count down on ticks only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else if (ce) begin
         if (load) begin
            cnt_r <= load_val;
         end else if (tick && !done) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule // rps_tick_timer
